// file: core/rlk_lock_key.sv
// Purpose: Lock-and-key guard for the indirect access port of the clock peripheral.
// Assumes: Register port and indirect-access strobes come from logic on clk_sys.
// Notes: Indirect register logic must only act while accessOk is high.
`timescale 1ns/1ps
module rlk_lock_key (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // Register port from the core
  input wire rlk_pkg::rlk_sfr_req_s sfrReq,
  output logic [7:0] rdData,
  output logic rdValid,
  // Indirect address or data register touched by software
  input wire logic indAccess,
  // Status toward the indirect registers
  output logic accessOk,
  output logic [1:0] lockState,
  output logic portDisabled
);

  // State encoding to the code software reads
  function automatic logic [1:0] stateCode(input rlk_pkg::rlk_state_e s);
    case (s)
      rlk_pkg::ST_LOCKED: stateCode = rlk_pkg::CODE_LOCKED;
      rlk_pkg::ST_FIRST: stateCode = rlk_pkg::CODE_FIRST;
      rlk_pkg::ST_OPEN: stateCode = rlk_pkg::CODE_OPEN;
      rlk_pkg::ST_DISABLED: stateCode = rlk_pkg::CODE_DISABLED;
      default: stateCode = rlk_pkg::CODE_DISABLED;
    endcase
  endfunction

  rlk_pkg::rlk_state_e state_reg;
  rlk_pkg::rlk_state_e state_next;
  logic keyHit;
  logic keyWr;
  logic keyRd;
  logic indAcc;
  logic invalidHit;
  logic [7:0] rdData_reg;
  logic rdValid_reg;
  logic accessOk_reg;
  logic [1:0] lockState_reg;
  logic portDisabled_reg;

  // Address decode; everything is frozen while ce is low
  assign keyHit = (sfrReq.addr == rlk_pkg::KEY_REG_ADDR);
  assign keyWr = ce & sfrReq.wrEn & keyHit;
  assign keyRd = ce & sfrReq.rdEn & keyHit;
  assign indAcc = ce & indAccess;

  rlk_key_next u_next (
    .state(state_reg),
    .keyWr(keyWr),
    .wrData(sfrReq.wrData),
    .indAccess(indAcc),
    .stateNext(state_next),
    .invalidHit(invalidHit)
  );

  // Lock machine; reset lands in the locked state
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= rlk_pkg::ST_LOCKED;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // Status outputs mirror the next state so they line up with state_reg
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      accessOk_reg <= 1'b0;
      lockState_reg <= rlk_pkg::CODE_LOCKED;
      portDisabled_reg <= 1'b0;
    end else if (ce) begin
      accessOk_reg <= (state_next == rlk_pkg::ST_OPEN);
      lockState_reg <= stateCode(state_next);
      portDisabled_reg <= (state_next == rlk_pkg::ST_DISABLED);
    end
  end

  // Read path: a read only samples state, it never feeds the machine
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdData_reg <= rlk_pkg::KEY_REG_RESET;
      rdValid_reg <= 1'b0;
    end else if (ce) begin
      rdValid_reg <= keyRd;
      if (keyRd) begin
        rdData_reg <= {6'h00, stateCode(state_reg)};
      end
    end
  end

  assign rdData = rdData_reg;
  assign rdValid = rdValid_reg;
  assign accessOk = accessOk_reg;
  assign lockState = lockState_reg;
  assign portDisabled = portDisabled_reg;

  // Checks next to the logic; all live on clk_sys
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  a_read_locked_zero: assert property (
    keyRd && state_reg == rlk_pkg::ST_LOCKED |=> rdValid && rdData == 8'h00)
    else $error("Locked read did not return zero");

  a_first_key_code: assert property (
    ce && state_reg == rlk_pkg::ST_LOCKED && keyWr && sfrReq.wrData == rlk_pkg::KEY_FIRST && !indAcc
    |=> lockState == 2'h1 && !accessOk)
    else $error("First key did not give code one");

  a_second_key_open: assert property (
    ce && state_reg == rlk_pkg::ST_FIRST && keyWr && sfrReq.wrData == rlk_pkg::KEY_SECOND && !indAcc
    |=> lockState == 2'h2 && accessOk)
    else $error("Second key did not unlock");

  a_disabled_sticky: assert property (
    state_reg == rlk_pkg::ST_DISABLED |=> state_reg == rlk_pkg::ST_DISABLED && lockState == 2'h3 && !accessOk)
    else $error("Disabled state was left before reset");

  // Helper state for the checks below; not part of the lock itself
  logic pairArmed;
  logic [5:0] waitCount;

  // Armed once the first key is taken from locked; any other key event disarms it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pairArmed <= 1'b0;
    end else if (ce) begin
      if (indAcc) begin
        pairArmed <= 1'b0;
      end else if (keyWr) begin
        pairArmed <= (state_reg == rlk_pkg::ST_LOCKED) && (sfrReq.wrData == rlk_pkg::KEY_FIRST);
      end
    end
  end

  // Cycles spent waiting for the second key; saturates so a long pause cannot wrap
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      waitCount <= 6'h00;
    end else if (ce) begin
      if (!pairArmed) begin
        waitCount <= 6'h00;
      end else if (waitCount != 6'h3f) begin
        waitCount <= waitCount + 6'h01;
      end
    end
  end

  a_key_pair_unlocks: assert property (
    pairArmed && keyWr && sfrReq.wrData == rlk_pkg::KEY_SECOND && !indAcc
    |=> accessOk && portDisabled == 1'b0)
    else $error("Key pair in order did not unlock");

  a_no_timeout: assert property (
    pairArmed && !keyWr && !indAcc |=> state_reg == rlk_pkg::ST_FIRST && lockState == rlk_pkg::CODE_FIRST)
    else $error("Wait for second key was cut short");

  a_wrong_second: assert property (
    state_reg == rlk_pkg::ST_FIRST && keyWr && sfrReq.wrData != rlk_pkg::KEY_SECOND
    |=> lockState == 2'h3 && portDisabled)
    else $error("Wrong second key did not disable");

  a_open_relock: assert property (
    state_reg == rlk_pkg::ST_OPEN && keyWr |=> lockState == 2'h0 && !accessOk)
    else $error("Write while unlocked did not relock");

  a_disabled_ignores: assert property (
    state_reg == rlk_pkg::ST_DISABLED && keyWr |=> $stable(lockState) && portDisabled)
    else $error("Write in disabled state had an effect");

  a_wrong_first: assert property (
    state_reg == rlk_pkg::ST_LOCKED && keyWr && sfrReq.wrData != rlk_pkg::KEY_FIRST
    |=> portDisabled ##1 !accessOk)
    else $error("Wrong first key did not disable");

  a_invalid_access: assert property (
    indAcc && state_reg != rlk_pkg::ST_OPEN && state_reg != rlk_pkg::ST_DISABLED
    |=> lockState == 2'h3 && !accessOk)
    else $error("Invalid indirect access did not disable");

  a_read_no_disturb: assert property (
    keyRd && !keyWr && !indAcc |=> $stable(state_reg) && rdData[1:0] == $past(lockState))
    else $error("Key read disturbed the sequence");

  a_ce_freeze: assert property (
    !ce |=> $stable(state_reg) && $stable(rdData) && $stable(accessOk))
    else $error("State moved while clock enable was low");

  a_invalid_hit_src: assert property (
    invalidHit |-> indAcc && state_reg != rlk_pkg::ST_OPEN && state_reg != rlk_pkg::ST_DISABLED)
    else $error("Invalid access flagged without a locked-state access");

  a_invalid_hit_effect: assert property (
    invalidHit |=> portDisabled && !accessOk)
    else $error("Flagged invalid access did not disable");

  a_open_access_ok: assert property (
    state_reg == rlk_pkg::ST_OPEN && indAcc && !keyWr |=> accessOk && !portDisabled)
    else $error("Indirect access while unlocked changed the state");

  a_rdvalid_pulse: assert property (
    !keyRd |=> !rdValid)
    else $error("Read answer without a key read");

  a_rd_upper_zero: assert property (
    rdValid |-> rdData[7:2] == 6'h00)
    else $error("Upper read bits not zero");

  a_status_agree: assert property (
    accessOk == (lockState == rlk_pkg::CODE_OPEN) && portDisabled == (lockState == rlk_pkg::CODE_DISABLED))
    else $error("Status outputs disagree with the state code");

  a_state_code: assert property (
    lockState == stateCode(state_reg))
    else $error("State code output does not follow the machine");

  a_foreign_addr: assert property (
    ce && (sfrReq.wrEn || sfrReq.rdEn) && !keyHit && !indAcc |=> $stable(state_reg) && $stable(lockState))
    else $error("Access to another address moved the machine");

  // Scenarios the bench is expected to reach
  c_unlock: cover property (pairArmed && keyWr && sfrReq.wrData == rlk_pkg::KEY_SECOND && !indAcc);
  c_late_unlock: cover property (waitCount > 6'h20 && keyWr && sfrReq.wrData == rlk_pkg::KEY_SECOND);
  c_disable_by_access: cover property (indAcc && state_reg == rlk_pkg::ST_FIRST);
  c_relock: cover property (state_reg == rlk_pkg::ST_OPEN && keyWr);
  c_read_disabled: cover property (keyRd && state_reg == rlk_pkg::ST_DISABLED);

endmodule

// file: core/rlk_pkg.sv
// Purpose: Shared constants and types for the interface lock-and-key block.
// Assumes: Byte-wide special-function register port on the system clock.
// Notes: One key register; indirect registers live outside this block.
// How it works
// - Key register resets to zero; reading zero means the port is locked.
// - After the first key byte, reads return code one: locked, awaiting second.
// - After both key bytes in order, reads return code two: unlocked.
// - Code three means disabled, and it holds until system reset.
// - From locked, writing first then second key byte unlocks the port.
// - Awaiting second key, any other written value disables the port.
// - While unlocked, any key register write locks the port again.
// - While disabled, key register writes are ignored.
// - Wrong first byte or out-of-order keys disable indirect access until reset.
// - Indirect access while not unlocked is invalid and disables the port.
// - Key reads never disturb the sequence; no time limit between key writes.
package rlk_pkg;

  // Register map and reset value
  localparam logic [7:0] KEY_REG_ADDR = 8'hae;
  localparam logic [7:0] KEY_REG_RESET = 8'h00;

  // Key bytes, written in this order
  localparam logic [7:0] KEY_FIRST = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'hf1;

  // State codes seen on a read, in the low bits
  localparam int CODE_W = 2;
  localparam logic [1:0] CODE_LOCKED = 2'h0;
  localparam logic [1:0] CODE_FIRST = 2'h1;
  localparam logic [1:0] CODE_OPEN = 2'h2;
  localparam logic [1:0] CODE_DISABLED = 2'h3;

  // Read data is returned this many cycles after the read strobe
  localparam int READ_LATENCY = 1;

  // Lock machine states
  typedef enum logic [1:0] {
    ST_LOCKED,
    ST_FIRST,
    ST_OPEN,
    ST_DISABLED
  } rlk_state_e;

  // One register-port access, as issued by the core in one cycle
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } rlk_sfr_req_s;

endpackage

// file: core/rlk_key_next.sv
// Purpose: Next-state decision of the lock machine.
// Assumes: Inputs already qualified by address decode and clock enable.
// Notes: Pure combinational; the caller holds the state flip-flop.
`timescale 1ns/1ps
module rlk_key_next (
  // Current state and events
  input wire rlk_pkg::rlk_state_e state,
  input wire logic keyWr,
  input wire logic [7:0] wrData,
  input wire logic indAccess,
  // Decision
  output rlk_pkg::rlk_state_e stateNext,
  output logic invalidHit
);

  // Indirect access outside the open state wins over any key write
  always_comb begin
    stateNext = state;
    invalidHit = 1'b0;
    case (state)
      rlk_pkg::ST_LOCKED: begin
        if (indAccess) begin
          stateNext = rlk_pkg::ST_DISABLED;
          invalidHit = 1'b1;
        end else if (keyWr) begin
          if (wrData == rlk_pkg::KEY_FIRST) begin
            stateNext = rlk_pkg::ST_FIRST;
          end else begin
            stateNext = rlk_pkg::ST_DISABLED;
          end
        end
      end
      rlk_pkg::ST_FIRST: begin
        if (indAccess) begin
          stateNext = rlk_pkg::ST_DISABLED;
          invalidHit = 1'b1;
        end else if (keyWr) begin
          if (wrData == rlk_pkg::KEY_SECOND) begin
            stateNext = rlk_pkg::ST_OPEN;
          end else begin
            stateNext = rlk_pkg::ST_DISABLED;
          end
        end
      end
      rlk_pkg::ST_OPEN: begin
        if (keyWr) begin
          stateNext = rlk_pkg::ST_LOCKED;
        end
      end
      rlk_pkg::ST_DISABLED: begin
        stateNext = rlk_pkg::ST_DISABLED;
      end
      default: begin
        stateNext = rlk_pkg::ST_DISABLED;
      end
    endcase
  end

endmodule

// file: testbench/rlk_lock_key_tb.sv
// Purpose: Self-checking bench for the interface lock-and-key block.
// Assumes: One 40 MHz clock; a key read answers right after its taking edge.
// Notes: Disabled states need a reset, so each scenario that disables the port starts from one.
`timescale 1ns/1ps
module rlk_lock_key_tb;
  logic clk_sys;
  logic nrst;
  logic ce;
  rlk_pkg::rlk_sfr_req_s sfrReq;
  logic indAccess;
  logic [7:0] rdData;
  logic rdValid;
  logic accessOk;
  logic [1:0] lockState;
  logic portDisabled;
  int miscompares;
  int cmpCount;

  rlk_lock_key i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .sfrReq(sfrReq), .rdData(rdData), .rdValid(rdValid),
    .indAccess(indAccess), .accessOk(accessOk), .lockState(lockState), .portDisabled(portDisabled)
  );

  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Single comparison point, four-state exact
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One-cycle write strobe; en low shows a frozen block
  task automatic wr(input logic [7:0] addr, input logic [7:0] data, input logic en = 1'b1);
    @(posedge clk_sys);
    ce <= en;
    sfrReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: addr, wrData: data};
    @(posedge clk_sys);
    sfrReq.wrEn <= 1'b0;
    ce <= 1'b1;
    #1;
  endtask

  // Key read: answer stands exactly one cycle
  task automatic rd(input logic [1:0] code);
    @(posedge clk_sys);
    sfrReq.rdEn <= 1'b1;
    sfrReq.addr <= rlk_pkg::KEY_REG_ADDR;
    @(posedge clk_sys);
    sfrReq.rdEn <= 1'b0;
    #1;
    chk("rdValid", {7'h00, rdValid}, 8'h01);
    chk("rdData", rdData, {6'h00, code});
    @(posedge clk_sys);
    #1;
    chk("rdValid end", {7'h00, rdValid}, 8'h00);
  endtask

  task automatic ind();
    @(posedge clk_sys);
    indAccess <= 1'b1;
    @(posedge clk_sys);
    indAccess <= 1'b0;
    #1;
  endtask

  // Status outputs all follow the one state code
  task automatic st(input logic [1:0] code);
    chk("lockState", {6'h00, lockState}, {6'h00, code});
    chk("accessOk", {7'h00, accessOk}, {7'h00, code == rlk_pkg::CODE_OPEN});
    chk("portDisabled", {7'h00, portDisabled}, {7'h00, code == rlk_pkg::CODE_DISABLED});
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    #1;
  endtask

  task automatic t_reset();
    st(rlk_pkg::CODE_LOCKED);
    rd(rlk_pkg::CODE_LOCKED);
    wr(rlk_pkg::KEY_REG_ADDR, rlk_pkg::KEY_FIRST, 1'b0);
    st(rlk_pkg::CODE_LOCKED);
    wr(8'had, rlk_pkg::KEY_FIRST);
    st(rlk_pkg::CODE_LOCKED);
    $display("test reset done");
  endtask

  task automatic t_unlock();
    wr(rlk_pkg::KEY_REG_ADDR, rlk_pkg::KEY_FIRST);
    st(rlk_pkg::CODE_FIRST);
    rd(rlk_pkg::CODE_FIRST);
    repeat (40) @(posedge clk_sys);
    wr(rlk_pkg::KEY_REG_ADDR, rlk_pkg::KEY_SECOND);
    st(rlk_pkg::CODE_OPEN);
    rd(rlk_pkg::CODE_OPEN);
    ind();
    st(rlk_pkg::CODE_OPEN);
    wr(rlk_pkg::KEY_REG_ADDR, rlk_pkg::KEY_SECOND);
    st(rlk_pkg::CODE_LOCKED);
    $display("test unlock done");
  endtask

  task automatic t_bad_second();
    do_reset();
    wr(rlk_pkg::KEY_REG_ADDR, rlk_pkg::KEY_FIRST);
    wr(rlk_pkg::KEY_REG_ADDR, 8'hf0);
    st(rlk_pkg::CODE_DISABLED);
    wr(rlk_pkg::KEY_REG_ADDR, rlk_pkg::KEY_FIRST);
    wr(rlk_pkg::KEY_REG_ADDR, rlk_pkg::KEY_SECOND);
    st(rlk_pkg::CODE_DISABLED);
    rd(rlk_pkg::CODE_DISABLED);
    $display("test bad second key done");
  endtask

  task automatic t_bad_order();
    do_reset();
    wr(rlk_pkg::KEY_REG_ADDR, rlk_pkg::KEY_SECOND);
    st(rlk_pkg::CODE_DISABLED);
    do_reset();
    wr(rlk_pkg::KEY_REG_ADDR, rlk_pkg::KEY_FIRST);
    ind();
    st(rlk_pkg::CODE_DISABLED);
    $display("test bad order done");
  endtask

  // Main sequence; every input has a value at time zero
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    sfrReq = '0;
    indAccess = 1'b0;
    miscompares = 0;
    cmpCount = 0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    #1;
    t_reset();
    t_unlock();
    t_bad_second();
    t_bad_order();
    wrap_up();
  end

  // Hang guard: the whole run is far shorter than this
  initial begin
    repeat (3000) @(posedge clk_sys);
    miscompares++;
    $display("unexpected run length: expected end, seen timeout");
    wrap_up();
  end
endmodule
